// *** src/scbgc_defines.svh ***
// scbgc_defines.svh: constants for the shared cache bus grant combine block
// assumes inclusion by bare name from src/ files
// Notes on behaviour
// R1 - any of four bus grants means granted
// R2 - any of four bus requests means requested
// R3 - any of four data grants means granted
// R4 - busy line only sampled while processor owns; the cache end samples it every cycle
// R5 - cache drives busy after qualified own grant
// R6 - fast mode needs busy pin held high; the cache end still pulls it during its own tenure
// R7 - two 32-bit halves, bit 0 is MSB; the code makes bit 31 the MSB
// R8 - eight parity bits travel with the data
// R9 - cache clock equals processor clock
// R10 - address busy qualifies grants, driven when mastering
// R11 - arbiter gives cache its own data grant
// R12 - control lines are active low
`ifndef SCBGC_DEFINES_SVH
`define SCBGC_DEFINES_SVH
`define SCBGC_NPROC      4
`define SCBGC_HALF_W     32
`define SCBGC_PAR_W      8
`define SCBGC_ASSERTED   1'b0
`define SCBGC_NEGATED    1'b1
`define SCBGC_BEATS_W    2
`define SCBGC_BEATS_LAST 2'h3
`endif

// *** src/scbgc_pkg.sv ***
// scbgc_pkg.sv: types shared by both ends
// assumes scbgc_defines.svh is reachable by bare name
`include "scbgc_defines.svh"
package scbgc_pkg;
  typedef logic [`SCBGC_HALF_W-1:0] scbgc_half_t;
  typedef logic [`SCBGC_PAR_W-1:0]  scbgc_par_t;
  typedef logic [`SCBGC_NPROC-1:0]  scbgc_lines_t;
endpackage

// *** src/scbgc_if.sv ***
// scbgc_if.sv: shared bus wires between the cache end and the system end
// assumes one clock for both ends; shared lines are resolved here
`timescale 1ns/1ps
`default_nettype none
`include "scbgc_defines.svh"
interface scbgc_if (
  input wire logic ref_clk
);
  scbgc_pkg::scbgc_lines_t proc_grant_n;
  scbgc_pkg::scbgc_lines_t proc_request_n;
  scbgc_pkg::scbgc_lines_t proc_data_grant_n;
  logic                    cache_data_grant_n;
  // open-drain style busy lines: each end gives value and enable
  logic                    dbb_cache_o;
  logic                    dbb_cache_oe;
  logic                    dbb_sys_o;
  logic                    dbb_sys_oe;
  logic                    abb_cache_o;
  logic                    abb_cache_oe;
  logic                    abb_sys_o;
  logic                    abb_sys_oe;
  wire                     data_bus_busy_n;
  wire                     addr_bus_busy_n;
  // data halves and parity, driven by one end at a time
  scbgc_pkg::scbgc_half_t  dh_cache_o;
  scbgc_pkg::scbgc_half_t  dl_cache_o;
  scbgc_pkg::scbgc_par_t   dp_cache_o;
  logic                    data_cache_oe;
  scbgc_pkg::scbgc_half_t  dh_sys_o;
  scbgc_pkg::scbgc_half_t  dl_sys_o;
  scbgc_pkg::scbgc_par_t   dp_sys_o;
  logic                    data_sys_oe;
  wire [`SCBGC_HALF_W-1:0] data_high_half;
  wire [`SCBGC_HALF_W-1:0] data_low_half;
  wire [`SCBGC_PAR_W-1:0]  data_parity_bits;

  // pullup resolution keeps an undriven busy line negated
  assign data_bus_busy_n = (dbb_cache_oe & ~dbb_cache_o) |
                           (dbb_sys_oe & ~dbb_sys_o) ? 1'b0 : 1'b1;
  assign addr_bus_busy_n = (abb_cache_oe & ~abb_cache_o) |
                           (abb_sys_oe & ~abb_sys_o) ? 1'b0 : 1'b1;
  assign data_high_half   = data_cache_oe ? dh_cache_o :
                            data_sys_oe ? dh_sys_o : '0;
  assign data_low_half    = data_cache_oe ? dl_cache_o :
                            data_sys_oe ? dl_sys_o : '0;
  assign data_parity_bits = data_cache_oe ? dp_cache_o :
                            data_sys_oe ? dp_sys_o : '0;

  modport cache (
    input  ref_clk, proc_grant_n, proc_request_n, proc_data_grant_n,
    input  cache_data_grant_n, data_bus_busy_n, addr_bus_busy_n,
    input  data_high_half, data_low_half, data_parity_bits,
    output dbb_cache_o, dbb_cache_oe, abb_cache_o, abb_cache_oe,
    output dh_cache_o, dl_cache_o, dp_cache_o, data_cache_oe
  );
  modport system (
    input  ref_clk, data_bus_busy_n, addr_bus_busy_n,
    input  data_high_half, data_low_half, data_parity_bits,
    output proc_grant_n, proc_request_n, proc_data_grant_n,
    output cache_data_grant_n,
    output dbb_sys_o, dbb_sys_oe, abb_sys_o, abb_sys_oe,
    output dh_sys_o, dl_sys_o, dp_sys_o, data_sys_oe
  );
endinterface
`default_nettype wire

// *** src/scbgc_cache_end.sv ***
// scbgc_cache_end.sv: cache side merge of grants and busy line ownership
// assumes ref_clk is the processor clock and bus inputs are synchronous
`timescale 1ns/1ps
`default_nettype none
`include "scbgc_defines.svh"
module scbgc_cache_end (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // shared bus
  scbgc_if.cache                 bus,
  // user side: address tenure and data tenure requests
  input  wire logic              addr_start,
  input  wire logic              addr_done,
  input  wire logic              data_start,
  input  wire logic              rd_not_wr,
  input  wire scbgc_pkg::scbgc_half_t rd_high,
  input  wire scbgc_pkg::scbgc_half_t rd_low,
  input  wire scbgc_pkg::scbgc_par_t  rd_par,
  // user side: merged view and captured data
  output logic                   any_grant,
  output logic                   any_request,
  output logic                   any_data_grant,
  output logic                   busy_seen,
  output logic                   data_owner,
  output logic                   wr_valid,
  output scbgc_pkg::scbgc_half_t wr_high,
  output scbgc_pkg::scbgc_half_t wr_low,
  output scbgc_pkg::scbgc_par_t  wr_par
);
  typedef enum logic [2:0] {
    SCBGC_IDLE = 3'b001,
    SCBGC_WAIT = 3'b010,
    SCBGC_OWN  = 3'b100
  } scbgc_dstate_t;

  scbgc_dstate_t                  dstate_r;
  scbgc_dstate_t                  dstate_nxt;
  logic                           rd_r;
  logic [`SCBGC_BEATS_W-1:0]      beat_r;
  logic                           addr_own_r;
  logic                           grant_any_w;
  logic                           req_any_w;
  logic                           dgrant_any_w;
  logic                           own_grant_w;
  logic                           qualified_w;
  logic                           in_idle_w;
  logic                           in_own_w;
  logic                           take_start_w;
  logic                           beat_last_w;
  logic                           wr_beat_w;
  logic                           busy_low_w;
  logic                           addr_take_w;
  scbgc_pkg::scbgc_lines_t        grant_on_w;
  scbgc_pkg::scbgc_lines_t        req_on_w;
  scbgc_pkg::scbgc_lines_t        dgrant_on_w;
  scbgc_pkg::scbgc_half_t         rd_high_r;
  scbgc_pkg::scbgc_half_t         rd_low_r;
  scbgc_pkg::scbgc_par_t          rd_par_r;

  ////////////////////////////////////////////////////////////////////////////
  // merged lines: each processor line is decoded on its own, then ORed,
  // so a wider processor count only widens the line type
  for (genvar p = 0; p < `SCBGC_NPROC; p++) begin : g_line
    assign grant_on_w[p]  = (bus.proc_grant_n[p] == `SCBGC_ASSERTED); // R12
    assign req_on_w[p]    = (bus.proc_request_n[p] == `SCBGC_ASSERTED); // R12
    assign dgrant_on_w[p] = (bus.proc_data_grant_n[p] == `SCBGC_ASSERTED);
  end
  assign grant_any_w  = |grant_on_w; // R1
  assign req_any_w    = |req_on_w; // R2
  assign dgrant_any_w = |dgrant_on_w; // R3
  assign own_grant_w  = (bus.cache_data_grant_n == `SCBGC_ASSERTED); // R11
  // own grant only counts once the previous data tenure has let go
  assign qualified_w  = own_grant_w &
                        (bus.data_bus_busy_n == `SCBGC_NEGATED); // R5
  // state decode shared by the tenure, the busy driver and write capture
  assign in_idle_w    = (dstate_r == SCBGC_IDLE);
  assign in_own_w     = (dstate_r == SCBGC_OWN);
  assign take_start_w = in_idle_w & data_start;
  assign beat_last_w  = (beat_r == `SCBGC_BEATS_LAST);
  assign wr_beat_w    = in_own_w & ~rd_r;
  assign busy_low_w   = (bus.data_bus_busy_n == `SCBGC_ASSERTED);
  // address tenure starts only on a granted, idle address bus
  assign addr_take_w  = addr_start & grant_any_w &
                        (bus.addr_bus_busy_n == `SCBGC_NEGATED); // R10

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    dstate_nxt = dstate_r;
    unique case (dstate_r)
      SCBGC_IDLE: begin
        if (data_start) begin
          dstate_nxt = SCBGC_WAIT;
        end
      end
      SCBGC_WAIT: begin
        if (qualified_w) begin
          dstate_nxt = SCBGC_OWN;
        end
      end
      SCBGC_OWN: begin
        if (beat_last_w) begin
          dstate_nxt = SCBGC_IDLE;
        end
      end
      default: dstate_nxt = SCBGC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dstate_r <= SCBGC_IDLE;
    end else begin
      dstate_r <= dstate_nxt;
    end
  end

  // beat count restarts outside a tenure, so each tenure is four beats
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      beat_r <= '0;
    end else begin
      beat_r <= in_own_w ? beat_r + 1'b1 : '0;
    end
  end

  // direction is latched with the start so a later change cannot flip it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_r <= 1'b0;
    end else if (take_start_w) begin
      rd_r <= rd_not_wr;
    end
  end

  // done wins over start: a stray start cannot keep the line held
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_own_r <= 1'b0;
    end else if (addr_done) begin
      addr_own_r <= 1'b0;
    end else if (addr_take_w) begin
      addr_own_r <= 1'b1; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy only driven in own tenure, otherwise released and sampled
  assign bus.dbb_cache_oe  = in_own_w; // R4 R5 R6
  assign bus.dbb_cache_o   = `SCBGC_ASSERTED;
  assign bus.abb_cache_oe  = addr_own_r; // R10
  assign bus.abb_cache_o   = `SCBGC_ASSERTED;
  assign bus.data_cache_oe = in_own_w & rd_r; // R8
  assign bus.dh_cache_o    = rd_high_r; // R7
  assign bus.dl_cache_o    = rd_low_r; // R7
  assign bus.dp_cache_o    = rd_par_r; // R8
  assign data_owner        = in_own_w;

  // read data leaves through flops loaded every cycle: the user holds it from the start,
  // and the wait for the grant covers the extra cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_high_r <= '0;
      rd_low_r  <= '0;
      rd_par_r  <= '0;
    end else begin
      rd_high_r <= rd_high;
      rd_low_r  <= rd_low;
      rd_par_r  <= rd_par;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // merged view, one cycle behind the lines
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      any_grant      <= 1'b0;
      any_request    <= 1'b0;
      any_data_grant <= 1'b0;
    end else begin
      any_grant      <= grant_any_w;
      any_request    <= req_any_w;
      any_data_grant <= dgrant_any_w;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_seen <= 1'b0;
    end else begin
      busy_seen <= busy_low_w; // R4
    end
  end

  // write data is captured on every owned write beat
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
    end else begin
      wr_valid <= wr_beat_w;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_high <= '0;
      wr_low  <= '0;
      wr_par  <= '0;
    end else if (wr_beat_w) begin
      wr_high <= bus.data_high_half; // R7
      wr_low  <= bus.data_low_half;
      wr_par  <= bus.data_parity_bits; // R8
    end
  end
endmodule
`default_nettype wire

// *** src/scbgc_system_end.sv ***
// scbgc_system_end.sv: processors and arbiter side of the shared bus
// assumes the same ref_clk feeds processors and cache
`timescale 1ns/1ps
`default_nettype none
`include "scbgc_defines.svh"
module scbgc_system_end (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  // shared bus
  scbgc_if.system                     bus,
  // user side: per-processor control, active high
  input  wire scbgc_pkg::scbgc_lines_t grant,
  input  wire scbgc_pkg::scbgc_lines_t request,
  input  wire scbgc_pkg::scbgc_lines_t data_grant,
  input  wire logic                   cache_grant,
  input  wire logic                   fast_cache_mode,
  input  wire logic                   proc_busy,
  input  wire logic                   proc_addr_busy,
  input  wire logic                   wr_drive,
  input  wire scbgc_pkg::scbgc_half_t wr_high,
  input  wire scbgc_pkg::scbgc_half_t wr_low,
  input  wire scbgc_pkg::scbgc_par_t  wr_par,
  // user side: sampled bus
  output logic                        busy_seen,
  output scbgc_pkg::scbgc_half_t      rd_high,
  output scbgc_pkg::scbgc_half_t      rd_low,
  output scbgc_pkg::scbgc_par_t       rd_par
);
  scbgc_pkg::scbgc_half_t wr_high_r;
  scbgc_pkg::scbgc_half_t wr_low_r;
  scbgc_pkg::scbgc_par_t  wr_par_r;

  ////////////////////////////////////////////////////////////////////////////
  // lines leave active low
  assign bus.proc_grant_n       = ~grant; // R12
  assign bus.proc_request_n     = ~request; // R12
  assign bus.proc_data_grant_n  = ~data_grant; // R12
  assign bus.cache_data_grant_n = ~cache_grant; // R11
  // fast mode keeps the system off the busy pin; the cache end still pulls it in its own tenure
  assign bus.dbb_sys_oe = proc_busy & ~fast_cache_mode; // R6
  assign bus.dbb_sys_o  = `SCBGC_ASSERTED;
  assign bus.abb_sys_oe = proc_addr_busy; // R10
  assign bus.abb_sys_o  = `SCBGC_ASSERTED;
  assign bus.data_sys_oe = wr_drive; // R8
  assign bus.dh_sys_o    = wr_high_r; // R7
  assign bus.dl_sys_o    = wr_low_r;
  assign bus.dp_sys_o    = wr_par_r;

  ////////////////////////////////////////////////////////////////////////////
  // ref_clk is the shared processor clock for both ends
  always_ff @(posedge ref_clk or negedge rst_n) begin // R9
    if (!rst_n) begin
      busy_seen <= 1'b0;
      rd_high   <= '0;
      rd_low    <= '0;
      rd_par    <= '0;
      wr_high_r <= '0;
      wr_low_r  <= '0;
      wr_par_r  <= '0;
    end else begin
      busy_seen <= (bus.data_bus_busy_n == `SCBGC_ASSERTED);
      rd_high   <= bus.data_high_half;
      rd_low    <= bus.data_low_half;
      rd_par    <= bus.data_parity_bits;
      wr_high_r <= wr_high;
      wr_low_r  <= wr_low;
      wr_par_r  <= wr_par;
    end
  end
endmodule
`default_nettype wire

// *** sim/scbgc_monitor.sv ***
// scbgc_monitor.sv: wire-level assertions on the shared bus
// assumes one clock; placed beside the interface instance
`timescale 1ns/1ps
`default_nettype none
module scbgc_monitor (
  // clock and reset
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  // bus lines
  input wire scbgc_pkg::scbgc_lines_t proc_grant_n,
  input wire logic                    cache_data_grant_n,
  input wire logic                    dbb_cache_o,
  input wire logic                    dbb_cache_oe,
  input wire logic                    dbb_sys_o,
  input wire logic                    dbb_sys_oe,
  input wire logic                    abb_cache_o,
  input wire logic                    abb_cache_oe,
  input wire logic                    data_bus_busy_n,
  input wire logic                    addr_bus_busy_n,
  input wire logic                    data_cache_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  AST_OWN_QUALIFIED: assert property ($rose(dbb_cache_oe) |->
    $past(!cache_data_grant_n && data_bus_busy_n)) else $error("bad own");
  AST_OWN_FOUR: assert property ($rose(dbb_cache_oe) |->
    dbb_cache_oe[*4] ##1 !dbb_cache_oe) else $error("own length");
  AST_OWN_DRIVES_LOW: assert property (dbb_cache_oe |->
    !dbb_cache_o && !data_bus_busy_n) else $error("busy not low");
  AST_NO_DRIVE_WHILE_BUSY: assert property (
    dbb_sys_oe && !dbb_sys_o && !dbb_cache_oe |=> !dbb_cache_oe)
    else $error("drove busy line");
  AST_ADDR_QUALIFIED: assert property ($rose(abb_cache_oe) |->
    $past(addr_bus_busy_n && proc_grant_n != 4'hf)) else $error("abb");
  AST_ADDR_DRIVES_LOW: assert property (abb_cache_oe |->
    !abb_cache_o ##0 !addr_bus_busy_n) else $error("abb not low");
  AST_DATA_IN_TENURE: assert property (data_cache_oe |->
    dbb_cache_oe) else $error("data outside tenure");
  AST_RELEASE: assert property ($fell(dbb_cache_oe) |->
    !data_cache_oe ##1 !dbb_cache_oe) else $error("no release");
endmodule
`default_nettype wire

// *** sim/shared_cache_bus_grant_combine_test.sv ***
// shared_cache_bus_grant_combine_test.sv: both ends joined, self-checking
// assumes design files and scbgc_monitor.sv compile first
`timescale 1ns/1ps
`default_nettype none
module shared_cache_bus_grant_combine_test;
  logic                    ref_clk, rst_n, rd_not_wr, cache_grant;
  logic                    addr_start, addr_done, data_start, wr_drive;
  logic                    fast_cache_mode, proc_busy, proc_addr_busy;
  logic                    any_grant, any_request, any_data_grant;
  logic                    c_busy_seen, s_busy_seen, data_owner, wr_valid;
  scbgc_pkg::scbgc_half_t  rd_high, rd_low, c_wr_high, c_wr_low;
  scbgc_pkg::scbgc_half_t  s_wr_high, s_wr_low, s_rd_high, s_rd_low;
  scbgc_pkg::scbgc_par_t   rd_par, c_wr_par, s_wr_par, s_rd_par;
  scbgc_pkg::scbgc_lines_t grant, request, data_grant;
  int                      error_cnt, compares, cycles;
  scbgc_if scbgc_if_i (.ref_clk(ref_clk));
  scbgc_cache_end scbgc_cache_end_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(scbgc_if_i), .addr_start(addr_start), .addr_done(addr_done),
    .data_start(data_start), .rd_not_wr(rd_not_wr), .rd_high(rd_high),
    .rd_low(rd_low), .rd_par(rd_par), .any_grant(any_grant),
    .any_request(any_request), .any_data_grant(any_data_grant),
    .busy_seen(c_busy_seen), .data_owner(data_owner), .wr_valid(wr_valid),
    .wr_high(c_wr_high), .wr_low(c_wr_low), .wr_par(c_wr_par));
  scbgc_system_end scbgc_system_end_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus(scbgc_if_i), .grant(grant), .request(request),
    .data_grant(data_grant), .cache_grant(cache_grant),
    .fast_cache_mode(fast_cache_mode), .proc_busy(proc_busy),
    .proc_addr_busy(proc_addr_busy), .wr_drive(wr_drive),
    .wr_high(s_wr_high), .wr_low(s_wr_low), .wr_par(s_wr_par),
    .busy_seen(s_busy_seen), .rd_high(s_rd_high), .rd_low(s_rd_low),
    .rd_par(s_rd_par));
  scbgc_monitor scbgc_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .proc_grant_n(scbgc_if_i.proc_grant_n),
    .cache_data_grant_n(scbgc_if_i.cache_data_grant_n),
    .dbb_cache_o(scbgc_if_i.dbb_cache_o),
    .dbb_cache_oe(scbgc_if_i.dbb_cache_oe),
    .dbb_sys_o(scbgc_if_i.dbb_sys_o), .dbb_sys_oe(scbgc_if_i.dbb_sys_oe),
    .abb_cache_o(scbgc_if_i.abb_cache_o),
    .abb_cache_oe(scbgc_if_i.abb_cache_oe),
    .data_bus_busy_n(scbgc_if_i.data_bus_busy_n),
    .addr_bus_busy_n(scbgc_if_i.addr_bus_busy_n),
    .data_cache_oe(scbgc_if_i.data_cache_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // pulse lasts one edge so the request is taken exactly once
  task automatic start_tenure(input logic rw);
    @(posedge ref_clk) data_start <= 1'b1;
    rd_not_wr <= rw;
    @(posedge ref_clk) data_start <= 1'b0;
  endtask
  task automatic wait_own();
    int w;
    w = 0;
    while (data_owner !== 1'b1 && w < 12) begin
      @(negedge ref_clk);
      w++;
    end
  endtask
  task automatic run_out(input int seen);
    int n;
    n = seen;
    while (data_owner === 1'b1 && n < 12) begin
      @(negedge ref_clk);
      if (data_owner === 1'b1) n++;
    end
    chk(n, 4);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_merge();
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk) grant <= 4'h1 << i;
      request <= 4'h8 >> i;
      data_grant <= 4'h1 << i;
      wait_n(2);
      chk(scbgc_if_i.proc_grant_n, 4'hf ^ (4'h1 << i));
      chk({any_grant, any_request, any_data_grant}, 3'h7);
    end
    @(posedge ref_clk) {grant, request, data_grant} <= '0;
    wait_n(2);
    chk({any_grant, any_request, any_data_grant}, 3'h0);
    $display("merge done");
  endtask
  task automatic t_read();
    @(posedge ref_clk) cache_grant <= 1'b1;
    {rd_high, rd_low, rd_par} <= {32'h8000_0001, 32'h7fff_fffe, 8'ha5};
    start_tenure(1'b1);
    wait_own();
    chk(scbgc_if_i.data_high_half, 32'h8000_0001);
    chk(scbgc_if_i.data_parity_bits, 8'ha5);
    wait_n(1);
    chk({s_rd_high, s_rd_low}, 64'h8000_0001_7fff_fffe);
    chk({s_busy_seen, s_rd_par}, 9'h1a5);
    run_out(2);
    @(posedge ref_clk) cache_grant <= 1'b0;
    $display("read done");
  endtask
  task automatic t_write();
    int w;
    @(posedge ref_clk) {cache_grant, wr_drive} <= 2'h3;
    {s_wr_high, s_wr_low, s_wr_par} <= {32'h1234_5678, 32'h0000_00ff, 8'h3c};
    start_tenure(1'b0);
    w = 0;
    while (wr_valid !== 1'b1 && w < 12) begin
      @(negedge ref_clk);
      w++;
    end
    chk({c_wr_high, c_wr_low}, 64'h1234_5678_0000_00ff);
    chk(c_wr_par, 8'h3c);
    run_out(2);
    @(posedge ref_clk) {cache_grant, wr_drive} <= 2'h0;
    $display("write done");
  endtask
  task automatic t_blocked();
    @(posedge ref_clk) {proc_busy, cache_grant} <= 2'h3;
    start_tenure(1'b1);
    wait_n(6);
    chk({data_owner, c_busy_seen}, 2'h1);
    @(posedge ref_clk) proc_busy <= 1'b0;
    wait_own();
    run_out(1);
    @(posedge ref_clk) {fast_cache_mode, proc_busy, cache_grant} <= 3'h6;
    wait_n(3);
    chk({scbgc_if_i.data_bus_busy_n, c_busy_seen}, 2'h2);
    @(posedge ref_clk) {fast_cache_mode, proc_busy} <= 2'h0;
    $display("blocked and fast done");
  endtask
  task automatic t_addr();
    @(posedge ref_clk) {grant, proc_addr_busy, addr_start} <= 6'h13;
    @(posedge ref_clk) addr_start <= 1'b0;
    wait_n(3);
    chk(scbgc_if_i.abb_cache_oe, 1'b0);
    @(posedge ref_clk) {proc_addr_busy, addr_start} <= 2'h1;
    @(posedge ref_clk) addr_start <= 1'b0;
    wait_n(2);
    chk(scbgc_if_i.addr_bus_busy_n, 1'b0);
    @(posedge ref_clk) addr_done <= 1'b1;
    @(posedge ref_clk) {addr_done, grant} <= '0;
    wait_n(2);
    chk(scbgc_if_i.abb_cache_oe, 1'b0);
    $display("address done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // run needs under a hundred cycles; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    {rst_n, rd_not_wr, cache_grant, addr_start, addr_done} = '0;
    {data_start, wr_drive, fast_cache_mode, proc_busy} = '0;
    {proc_addr_busy, grant, request, data_grant} = '0;
    {rd_high, rd_low, rd_par, s_wr_high, s_wr_low, s_wr_par} = '0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_merge();
    t_read();
    t_write();
    t_blocked();
    t_addr();
    end_of_test();
  end
endmodule
`default_nettype wire
